// [src/sbcra_reg_access.sv]
`default_nettype none
module sbcra_reg_access
	import sbcra_pkg::*;
#(
	parameter logic [7:0] FAMILY_ID = 8'h5A, // Arbitrary identity value
	parameter int RESTART_CYCLES = RESTART_CYC
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic sclk,
	input wire logic csn,
	input wire logic sdi,
	output logic sdo,
	input wire logic [7:0] busAddr,
	input wire logic [7:0] busWdata,
	input wire logic busWr,
	input wire logic busRd,
	output logic [7:0] busRdata,
	output logic irq,
	input wire logic wakeEvent,
	input wire logic restartReq,
	input wire logic failEvent,
	input wire logic [7:0] supplyFlags,
	input wire logic [3:0] hsFault,
	input wire logic [2:0] wakePinLevel,
	output logic [1:0] modeNow,
	output logic [3:0] hsEnable,
	output logic [1:0] secondRegOn,
	output logic thirdRegOn,
	output logic [2:0] canMode,
	output logic [1:0] lin1Mode,
	output logic [1:0] lin2Mode,
	output logic failOut
);
	// ********************
	// Declarations
	// ********************
	logic [7:0] ctrlMem_reg [CTRL_CNT]; // Control storage
	logic [7:0] statMem_reg [STS_CNT]; // Clearable status
	sbcra_mode_t mode_reg, mode_next; // Actual device mode
	logic [15:0] rstCnt_reg; // Restart dwell counter
	logic [2:0] wakeLvlS1, wakeLvlS2; // Live pin level sync
	logic [IRQ_W-1:0] irqSts_reg, irqMask_reg;
	logic irq_reg;
	logic [7:0] busRdata_reg;
	logic [7:0] respHigh_reg, infoByte_reg;
	logic respLoad_reg;
	logic failOut_reg;
	logic hdrStrobe, frameStrobe, frameOk;
	logic [6:0] hdrAddr;
	sbcra_frame_t frm; // Completed frame
	logic frameUse; // Good frame outside restart
	logic ctrlWr, statClr, modeChg;
	logic [7:0] ctrlWrData, hsBase;
	logic [IRQ_W-1:0] irqSet;
	// ********************
	// Helpers
	// ********************
	// Control address decode
	function automatic logic isCtrl(input logic [6:0] a);
		return a <= CTRL_LAST;
	endfunction
	// Status address decode
	function automatic logic isStat(input logic [6:0] a);
		return a >= STAT_FIRST && a <= STAT_LAST;
	endfunction
	// Slot of a clearable status register, or none
	function automatic logic [2:0] statSlot(input logic [6:0] a);
		case (a)
			STS_SUPPLY: return 3'b100;
			STS_DEV: return 3'b101;
			STS_WAKE: return 3'b110;
			STS_HS_OVL: return 3'b111;
			default: return 3'b000;
		endcase
	endfunction
	// Byte shown for an address; reads have no side effect
	function automatic logic [7:0] readByte(input logic [6:0] a);
		logic [2:0] s;
		s = statSlot(a);
		if (isCtrl(a)) begin
			return ctrlMem_reg[a[4:0]];
		end else if (s[2]) begin
			return statMem_reg[s[1:0]];
		end else if (a == STS_WAKE_LVL) begin
			return {5'h00, wakeLvlS2};
		end else if (a == STS_FAM_ID) begin
			return FAMILY_ID;
		end
		return 8'h00;
	endfunction
	// Park a CAN setting: off stays off, else wake capable
	function automatic logic [2:0] parkCan(input logic [2:0] c);
		return (c == CAN_OFF) ? CAN_OFF : CAN_WAKE;
	endfunction
	// Park a LIN setting the same way
	function automatic logic [1:0] parkLin(input logic [1:0] c);
		return (c == LIN_OFF) ? LIN_OFF : LIN_WAKE;
	endfunction
	// ********************
	// Serial framing
	// ********************
	sbcra_spi_shift u_shift (
		.clk(clk),
		.resetn(resetn),
		.sclk(sclk),
		.csn(csn),
		.sdi(sdi),
		.respLow(infoByte_reg),
		.respHigh(respHigh_reg),
		.respLoad(respLoad_reg),
		.hdrStrobe(hdrStrobe),
		.hdrAddr(hdrAddr),
		.frameStrobe(frameStrobe),
		.frameOk(frameOk),
		.frame(frm),
		.sdo(sdo)
	);
	// Pin level crosses into clk domain
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wakeLvlS1 <= 3'b000;
			wakeLvlS2 <= 3'b000;
		end else begin
			wakeLvlS1 <= wakePinLevel;
			wakeLvlS2 <= wakeLvlS1;
		end
	end
	// ********************
	// Frame decode
	// ********************
	assign frameUse = frameStrobe && frameOk && mode_reg != MD_RESTART;
	// Only the switch config write is dropped whole in sleep or stop; restart drops every frame
	assign ctrlWr = frameUse && frm.wrSel && isCtrl(frm.addr) &&
		!(frm.addr == HS_CTRL && mode_reg != MD_NORMAL);
	assign statClr = frameUse && frm.wrSel && isStat(frm.addr);
	assign hsBase = (ctrlWr && frm.addr == HS_CTRL) ? frm.data : ctrlMem_reg[HS_CTRL[4:0]];
	// Regulator bits keep their value when written outside normal
	always_comb begin
		ctrlWrData = frm.data;
		if (frm.addr == MODE_CTRL && mode_reg != MD_NORMAL) begin
			ctrlWrData[THIRD_BIT:SECOND_LO] = ctrlMem_reg[0][THIRD_BIT:SECOND_LO];
		end
	end
	// Response bytes: info field first, addressed byte after header
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			respHigh_reg <= 8'h00;
			respLoad_reg <= 1'b0;
			infoByte_reg <= 8'h00;
		end else begin
			respLoad_reg <= hdrStrobe;
			for (int i = 0; i < STS_CNT; i++) begin
				infoByte_reg[i] <= |statMem_reg[i];
			end
			infoByte_reg[7:STS_CNT] <= '0;
			if (mode_reg == MD_RESTART) begin
				// Bus is not served; answer reads as all ones
				respHigh_reg <= 8'hFF;
				infoByte_reg <= 8'hFF;
			end else if (hdrStrobe) begin
				// Old value goes out; a write lands at frame end
				respHigh_reg <= readByte(hdrAddr);
			end
		end
	end
	// ********************
	// Mode control
	// ********************
	// Next mode from requests, wakes and restart dwell
	always_comb begin
		mode_next = mode_reg;
		case (mode_reg)
			MD_NORMAL: begin
				if (ctrlWr && frm.addr == MODE_CTRL) begin
					mode_next = sbcra_mode_t'(frm.data[MODE_HI:MODE_LO]);
				end
			end
			MD_SLEEP: begin
				if (wakeEvent) begin
					mode_next = MD_RESTART;
				end
			end
			MD_STOP: begin
				// Stop may be left over the serial port
				if (wakeEvent) begin
					mode_next = MD_NORMAL;
				end else if (ctrlWr && frm.addr == MODE_CTRL &&
						frm.data[MODE_HI:MODE_LO] == MD_NORMAL) begin
					mode_next = MD_NORMAL;
				end
			end
			MD_RESTART: begin
				if (rstCnt_reg >= 16'(RESTART_CYCLES - 1)) begin
					mode_next = MD_NORMAL;
				end
			end
			default: mode_next = MD_RESTART;
		endcase
		if (restartReq) begin
			mode_next = MD_RESTART;
		end
	end
	// Hardware faults never feed the mode logic: no wake from them
	assign modeChg = mode_next != mode_reg;
	// Mode state and restart dwell
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mode_reg <= MD_NORMAL;
			rstCnt_reg <= 16'h0000;
		end else begin
			mode_reg <= mode_next;
			if (mode_reg != MD_RESTART || modeChg) begin
				rstCnt_reg <= 16'h0000;
			end else begin
				rstCnt_reg <= rstCnt_reg + 16'h0001;
			end
		end
	end
	// ********************
	// Control registers
	// ********************
	// Serial writes first, hardware updates override
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < CTRL_CNT; i++) begin
				ctrlMem_reg[i] <= CTRL_RST;
			end
		end else begin
			if (ctrlWr) begin
				ctrlMem_reg[frm.addr[4:0]] <= ctrlWrData;
			end
			// Faulty switch is turned off in any mode, flags do not block
			if (|hsFault) begin
				ctrlMem_reg[HS_CTRL[4:0]] <= hsBase & ~{4'h0, hsFault};
			end
			if (modeChg) begin
				ctrlMem_reg[0][MODE_HI:MODE_LO] <= mode_next;
				case (mode_next)
					MD_SLEEP: begin
						ctrlMem_reg[BUS_CTRL_A[4:0]][2:0] <= parkCan(ctrlMem_reg[BUS_CTRL_A[4:0]][2:0]);
						ctrlMem_reg[BUS_CTRL_A[4:0]][4:3] <= parkLin(ctrlMem_reg[BUS_CTRL_A[4:0]][4:3]);
						ctrlMem_reg[BUS_CTRL_B[4:0]][1:0] <= parkLin(ctrlMem_reg[BUS_CTRL_B[4:0]][1:0]);
					end
					MD_RESTART: begin
						ctrlMem_reg[HS_CTRL[4:0]] <= 8'h00;
						ctrlMem_reg[0][SECOND_HI:SECOND_LO] <= 2'b00;
						ctrlMem_reg[BUS_CTRL_A[4:0]][2:0] <= parkCan(ctrlMem_reg[BUS_CTRL_A[4:0]][2:0]);
						ctrlMem_reg[BUS_CTRL_A[4:0]][4:3] <= parkLin(ctrlMem_reg[BUS_CTRL_A[4:0]][4:3]);
						ctrlMem_reg[BUS_CTRL_B[4:0]][1:0] <= parkLin(ctrlMem_reg[BUS_CTRL_B[4:0]][1:0]);
					end
					// Stop and normal leave transceivers and switches running
					default: begin
					end
				endcase
			end
		end
	end
	// ********************
	// Status registers
	// ********************
	// Set wins over a clear in the same cycle; kept in low power
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < STS_CNT; i++) begin
				statMem_reg[i] <= 8'h00;
			end
		end else begin
			for (int i = 0; i < STS_CNT; i++) begin
				logic [7:0] setBits;
				logic [2:0] slot;
				setBits = 8'h00;
				slot = statSlot(frm.addr);
				case (i)
					0: setBits = supplyFlags;
					1: setBits = {7'h00, failEvent};
					2: setBits = {7'h00, wakeEvent};
					default: setBits = {4'h0, hsFault};
				endcase
				// Only slotted registers clear; others never do
				if (statClr && slot[2] && slot[1:0] == 2'(i)) begin
					statMem_reg[i] <= setBits;
				end else begin
					statMem_reg[i] <= statMem_reg[i] | setBits;
				end
			end
		end
	end
	// Fail output latches until reset, across all modes
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			failOut_reg <= 1'b0;
		end else if (failEvent) begin
			failOut_reg <= 1'b1;
		end
	end
	// ********************
	// Local bus and interrupt
	// ********************
	assign irqSet = {|hsFault, modeChg, frameStrobe & ~frameOk, frameUse};
	// Sticky events, write one to clear, set wins
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irqSts_reg <= '0;
			irqMask_reg <= '0;
			irq_reg <= 1'b0;
		end else begin
			if (busWr && busAddr == REG_IRQ_STS) begin
				irqSts_reg <= (irqSts_reg & ~busWdata[IRQ_W-1:0]) | irqSet;
			end else begin
				irqSts_reg <= irqSts_reg | irqSet;
			end
			if (busWr && busAddr == REG_IRQ_MASK) begin
				irqMask_reg <= busWdata[IRQ_W-1:0];
			end
			irq_reg <= |(irqSts_reg & irqMask_reg);
		end
	end
	// Read data stands one cycle; unmapped reads zero
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			busRdata_reg <= 8'h00;
		end else if (!busRd) begin
			busRdata_reg <= 8'h00;
		end else if (!busAddr[7]) begin
			busRdata_reg <= readByte(busAddr[6:0]);
		end else begin
			case (busAddr)
				REG_IRQ_STS: busRdata_reg <= {4'h0, irqSts_reg};
				REG_IRQ_MASK: busRdata_reg <= {4'h0, irqMask_reg};
				REG_MODE: busRdata_reg <= {6'h00, mode_reg};
				default: busRdata_reg <= 8'h00;
			endcase
		end
	end
	// ********************
	// Outputs
	// ********************
	assign busRdata = busRdata_reg;
	assign irq = irq_reg;
	assign modeNow = mode_reg;
	assign hsEnable = ctrlMem_reg[HS_CTRL[4:0]][3:0];
	assign secondRegOn = ctrlMem_reg[0][SECOND_HI:SECOND_LO];
	assign thirdRegOn = ctrlMem_reg[0][THIRD_BIT];
	assign canMode = ctrlMem_reg[BUS_CTRL_A[4:0]][2:0];
	assign lin1Mode = ctrlMem_reg[BUS_CTRL_A[4:0]][4:3];
	assign lin2Mode = ctrlMem_reg[BUS_CTRL_B[4:0]][1:0];
	assign failOut = failOut_reg;
endmodule // sbcra_reg_access
`default_nettype wire

// [src/sbcra_pkg.sv]
`default_nettype none
package sbcra_pkg;
	// ********************
	// Frame and map layout
	// ********************
	localparam int FRAME_BITS = 16; // Clocks in a valid frame
	localparam int HDR_BITS = 8; // Address plus selector
	localparam logic [6:0] CTRL_LAST = 7'h1E; // Last control address
	localparam logic [6:0] STAT_FIRST = 7'h40; // First status address
	localparam logic [6:0] STAT_LAST = 7'h7E; // Last status address
	localparam int CTRL_CNT = 32; // Control storage slots
	localparam logic [7:0] CTRL_RST = 8'h00; // Control reset value
	// Control registers used by the mode logic
	localparam logic [6:0] MODE_CTRL = 7'h00;
	localparam logic [6:0] BUS_CTRL_A = 7'h03;
	localparam logic [6:0] BUS_CTRL_B = 7'h04;
	localparam logic [6:0] HS_CTRL = 7'h14;
	// Fields of the mode control register
	localparam int MODE_HI = 7;
	localparam int MODE_LO = 6;
	localparam int THIRD_BIT = 5;
	localparam int SECOND_HI = 4;
	localparam int SECOND_LO = 3;
	// Transceiver field codes
	localparam logic [2:0] CAN_OFF = 3'b000;
	localparam logic [2:0] CAN_WAKE = 3'b001;
	localparam logic [1:0] LIN_OFF = 2'b00;
	localparam logic [1:0] LIN_WAKE = 2'b01;
	// Clearable status registers
	localparam logic [6:0] STS_SUPPLY = 7'h41;
	localparam logic [6:0] STS_DEV = 7'h43;
	localparam logic [6:0] STS_WAKE = 7'h46;
	localparam logic [6:0] STS_HS_OVL = 7'h54;
	localparam int STS_CNT = 4;
	// Registers that never clear
	localparam logic [6:0] STS_WAKE_LVL = 7'h48;
	localparam logic [6:0] STS_FAM_ID = 7'h7E;
	// ********************
	// Local bus map
	// ********************
	localparam logic [7:0] REG_IRQ_STS = 8'h80;
	localparam logic [7:0] REG_IRQ_MASK = 8'h81;
	localparam logic [7:0] REG_MODE = 8'h82;
	localparam int IRQ_W = 4;
	localparam int EV_FRAME = 0;
	localparam int EV_FRAME_ERR = 1;
	localparam int EV_MODE = 2;
	localparam int EV_HS_FAULT = 3;
	// ********************
	// Timing
	// ********************
	localparam int CLK_MHZ = 100;
	localparam int RESTART_NS = 2000; // Restart dwell time
	localparam int RESTART_CYC = (RESTART_NS * CLK_MHZ + 999) / 1000;
	// ********************
	// Types
	// ********************
	typedef enum logic [1:0] {
		MD_NORMAL = 2'b00,
		MD_SLEEP = 2'b01,
		MD_STOP = 2'b10,
		MD_RESTART = 2'b11
	} sbcra_mode_t;
	typedef struct packed {
		logic [7:0] data; // Bits 15..8
		logic wrSel; // Bit 7
		logic [6:0] addr; // Bits 6..0
	} sbcra_frame_t;
endpackage
`default_nettype wire

// [src/sbcra_spi_shift.sv]
`default_nettype none
module sbcra_spi_shift
	import sbcra_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic sclk,
	input wire logic csn,
	input wire logic sdi,
	input wire logic [7:0] respLow,
	input wire logic [7:0] respHigh,
	input wire logic respLoad,
	output logic hdrStrobe,
	output logic [6:0] hdrAddr,
	output logic frameStrobe,
	output logic frameOk,
	output sbcra_frame_t frame,
	output logic sdo
);
	// ********************
	// Pin synchronisers
	// ********************
	logic sclkS1, sclkS2, sclkS3; // S3 only for edge finding
	logic csnS1, csnS2, csnS3;
	logic sdiS1, sdiS2;
	logic [15:0] shiftIn_reg; // LSB arrives first
	logic [4:0] bitCnt_reg; // Rising edges seen
	logic [4:0] outIdx_reg; // Bit now on sdo
	logic [7:0] lowByte_reg, highByte_reg;
	logic active_reg; // Inside a frame
	logic rise, fall, csnFall, csnRise;

	// Two stages before any logic looks
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			{sclkS1, sclkS2, sclkS3} <= 3'b000;
			{csnS1, csnS2, csnS3} <= 3'b111;
			{sdiS1, sdiS2} <= 2'b00;
		end else begin
			{sclkS1, sclkS2, sclkS3} <= {sclk, sclkS1, sclkS2};
			{csnS1, csnS2, csnS3} <= {csn, csnS1, csnS2};
			{sdiS1, sdiS2} <= {sdi, sdiS1};
		end
	end

	assign rise = sclkS2 & ~sclkS3 & active_reg;
	assign fall = ~sclkS2 & sclkS3 & active_reg;
	assign csnFall = ~csnS2 & csnS3;
	assign csnRise = csnS2 & ~csnS3;

	// ********************
	// Receive side
	// ********************
	// Sample on rising clock, count saturates so long frames fail
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			shiftIn_reg <= 16'h0000;
			bitCnt_reg <= 5'h00;
			active_reg <= 1'b0;
			hdrStrobe <= 1'b0;
			hdrAddr <= 7'h00;
			frameStrobe <= 1'b0;
			frameOk <= 1'b0;
			frame <= '0;
		end else begin
			hdrStrobe <= 1'b0;
			frameStrobe <= 1'b0;
			if (csnFall) begin
				active_reg <= 1'b1;
				bitCnt_reg <= 5'h00;
			end else if (csnRise && active_reg) begin
				active_reg <= 1'b0;
				frameStrobe <= 1'b1;
				// Clock high at chip select edge also spoils the frame
				frameOk <= (bitCnt_reg == 5'(FRAME_BITS)) && !sclkS2;
				frame <= shiftIn_reg;
			end else if (rise) begin
				shiftIn_reg <= {sdiS2, shiftIn_reg[15:1]};
				if (bitCnt_reg != 5'h1F) begin
					bitCnt_reg <= bitCnt_reg + 5'h01;
				end
				if (bitCnt_reg == 5'(HDR_BITS - 1)) begin
					hdrStrobe <= 1'b1;
					hdrAddr <= shiftIn_reg[15:9];
				end
			end
		end
	end

	// ********************
	// Transmit side
	// ********************
	// Advance on falling clock; high byte arrives mid frame
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			outIdx_reg <= 5'h00;
			lowByte_reg <= 8'h00;
			highByte_reg <= 8'h00;
			sdo <= 1'b0;
		end else begin
			if (csnFall) begin
				outIdx_reg <= 5'h00;
				lowByte_reg <= respLow;
			end else if (fall && outIdx_reg != 5'h1F) begin
				outIdx_reg <= outIdx_reg + 5'h01;
			end
			if (respLoad) begin
				highByte_reg <= respHigh;
			end
			if (!active_reg) begin
				sdo <= 1'b0;
			end else if (outIdx_reg < 5'(HDR_BITS)) begin
				sdo <= lowByte_reg[outIdx_reg[2:0]];
			end else begin
				sdo <= highByte_reg[outIdx_reg[2:0]];
			end
		end
	end
endmodule // sbcra_spi_shift
`default_nettype wire

// [sim/sbcra_reg_access_chk.sv]
`default_nettype none
module sbcra_reg_access_chk
	import sbcra_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] busAddr,
	input wire logic [7:0] busWdata,
	input wire logic busWr,
	input wire logic busRd,
	input wire logic [7:0] busRdata,
	input wire logic irq,
	input wire logic wakeEvent,
	input wire logic [3:0] hsFault,
	input wire logic [1:0] modeNow,
	input wire logic [3:0] hsEnable,
	input wire logic [1:0] secondRegOn,
	input wire logic thirdRegOn,
	input wire logic [2:0] canMode,
	input wire logic [1:0] lin1Mode,
	input wire logic [1:0] lin2Mode,
	input wire logic failOut
);
	timeunit 1ns;
	timeprecision 100ps;
	// ********************
	// Properties
	// ********************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// Every transceiver off or wake capable
	wire logic parked = (canMode inside {CAN_OFF, CAN_WAKE}) && (lin1Mode inside {LIN_OFF, LIN_WAKE})
		&& (lin2Mode inside {LIN_OFF, LIN_WAKE});
	// Read data only in the answer cycle
	AST_RDATA_SLOT: assert property (busRdata != 8'h00 |-> $past(busRd)) else $error("stray read data");
	// Mask cleared silences the line; allows for the registered lag
	AST_MASK_SILENCES: assert property (busWr && busAddr == REG_IRQ_MASK && busWdata == 8'h00 |-> ##3 !irq)
		else $error("irq high with mask cleared");
	AST_FAIL_STICKY: assert property (failOut |=> failOut) else $error("fail output dropped");
	AST_HS_FAULT_OFF: assert property (hsFault[0] |-> ##[1:3] !hsEnable[0]) else $error("switch kept on");
	// A fault in sleep never wakes the device
	AST_HS_NO_WAKE: assert property (hsFault != 4'h0 && modeNow == MD_SLEEP && !wakeEvent |=>
		modeNow == MD_SLEEP) else $error("fault left sleep");
	AST_SLEEP_PARKS: assert property (modeNow == MD_SLEEP && $past(modeNow) == MD_SLEEP
		&& $past(modeNow, 2) == MD_SLEEP |-> parked) else $error("transceiver active in sleep");
	// Entering or staying in stop never touches transceivers
	AST_STOP_KEEPS: assert property (modeNow == MD_STOP |-> $stable(canMode) && $stable(lin1Mode)
		&& $stable(lin2Mode)) else $error("transceiver changed in stop");
	AST_RESTART_CLEARS: assert property ($rose(modeNow == MD_RESTART) |-> ##[0:2]
		(hsEnable == 4'h0 && secondRegOn == 2'b00)) else $error("restart kept switch config");
	AST_RESTART_PARKS: assert property (modeNow == MD_RESTART && $past(modeNow) == MD_RESTART
		&& $past(modeNow, 2) == MD_RESTART |-> parked) else $error("transceiver active in restart");
	// Regulator config frozen while in sleep or stop
	AST_LOWPOWER_CFG: assert property (modeNow inside {MD_SLEEP, MD_STOP} && $past(modeNow) == modeNow
		|-> $stable(secondRegOn) && $stable(thirdRegOn)) else $error("regulator config changed");
	AST_SLEEP_WAKE: assert property (modeNow == MD_SLEEP && wakeEvent |-> ##[1:3] modeNow == MD_RESTART)
		else $error("wake ignored in sleep");
	// Main scenarios
	cover property (modeNow == MD_SLEEP ##1 modeNow == MD_RESTART);
	cover property (busRd ##1 busRdata != 8'h00);
	cover property (modeNow == MD_STOP && canMode != CAN_OFF);
endmodule // sbcra_reg_access_chk
bind sbcra_reg_access sbcra_reg_access_chk u_chk (.clk(clk), .resetn(resetn), .busAddr(busAddr),
	.busWdata(busWdata), .busWr(busWr), .busRd(busRd), .busRdata(busRdata), .irq(irq), .wakeEvent(wakeEvent),
	.hsFault(hsFault), .modeNow(modeNow), .hsEnable(hsEnable), .secondRegOn(secondRegOn),
	.thirdRegOn(thirdRegOn), .canMode(canMode), .lin1Mode(lin1Mode), .lin2Mode(lin2Mode), .failOut(failOut));
`default_nettype wire

// [sim/sbcra_spi_master.sv]
`default_nettype none
module sbcra_spi_master
	import sbcra_pkg::*;
(
	output logic sclk,
	output logic csn,
	output logic sdi,
	input wire logic sdo
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int HALF_NS = 80; // Link clock half period
	// ********************
	// Serial master
	// ********************
	// Idle: clock parked low, device deselected
	initial begin
		sclk = 1'b0;
		csn = 1'b1;
		sdi = 1'b0;
	end
	// One frame LSB first; nbits other than 16 gives a refused frame
	task automatic xfer(input sbcra_frame_t f, input int nbits, input int gapNs, output logic [15:0] resp);
		logic [15:0] w;
		w = f;
		resp = 16'h0000;
		#3; // Phase unrelated to the system clock
		csn = 1'b0;
		for (int k = 0; k < nbits; k++) begin
			sdi = w[k % 16];
			#HALF_NS;
			resp[k % 16] = sdo;
			sclk = 1'b1;
			#HALF_NS;
			sclk = 1'b0;
		end
		#HALF_NS;
		csn = 1'b1; // Clock low at both select edges
		sdi = ~sdi; // Released line shows no stale level
		#(gapNs);
	endtask
endmodule // sbcra_spi_master
`default_nettype wire

// [sim/sbcra_reg_access_test.sv]
`default_nettype none
module sbcra_reg_access_test import sbcra_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	// ********************
	// Signals
	// ********************
	localparam int RST_CYC = 600; // Dwell outlasts one whole frame
	logic clk, resetn, sclk, csn, sdi, sdo, busWr, busRd, irq, thirdRegOn, failOut;
	logic wakeEvent, restartReq, failEvent;
	logic [7:0] busAddr, busWdata, busRdata, supplyFlags;
	logic [3:0] hsFault, hsEnable;
	logic [2:0] wakePinLevel, canMode;
	logic [1:0] modeNow, secondRegOn, lin1Mode, lin2Mode;
	logic [15:0] resp; // Last serial answer
	int n_fail = 0;
	int cmp_count = 0;
	sbcra_reg_access #(.RESTART_CYCLES(RST_CYC)) i_dut (.clk(clk), .resetn(resetn), .sclk(sclk), .csn(csn),
		.sdi(sdi), .sdo(sdo), .busAddr(busAddr), .busWdata(busWdata), .busWr(busWr), .busRd(busRd),
		.busRdata(busRdata), .irq(irq), .wakeEvent(wakeEvent), .restartReq(restartReq), .failEvent(failEvent),
		.supplyFlags(supplyFlags), .hsFault(hsFault), .wakePinLevel(wakePinLevel), .modeNow(modeNow),
		.hsEnable(hsEnable), .secondRegOn(secondRegOn), .thirdRegOn(thirdRegOn), .canMode(canMode),
		.lin1Mode(lin1Mode), .lin2Mode(lin2Mode), .failOut(failOut));
	sbcra_spi_master i_master (.sclk(sclk), .csn(csn), .sdi(sdi), .sdo(sdo));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ********************
	// Tasks
	// ********************
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Local bus write, one strobe cycle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		busAddr <= a;
		busWdata <= d;
		busWr <= 1'b1;
		@(posedge clk);
		busWr <= 1'b0;
	endtask
	// Local bus read; data valid only the next cycle
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		busAddr <= a;
		busRd <= 1'b1;
		@(posedge clk);
		busRd <= 1'b0;
		#1;
		chk(busRdata, exp);
	endtask
	// One-cycle event pulse: switch faults, {wake, restart, fail}, supply flags
	task automatic ev(input logic [3:0] hs, input logic [2:0] wrf, input logic [7:0] sup);
		@(posedge clk);
		hsFault <= hs;
		{wakeEvent, restartReq, failEvent} <= wrf;
		supplyFlags <= sup;
		@(posedge clk);
		hsFault <= 4'h0;
		{wakeEvent, restartReq, failEvent} <= 3'b000;
		supplyFlags <= 8'h00;
		repeat (4) @(posedge clk);
		#1;
	endtask
	// Serial frame; answer byte compared with the value before the frame
	task automatic spi(input logic [6:0] a, input logic w, input logic [7:0] d, input logic [7:0] exp);
		i_master.xfer(sbcra_frame_t'{d, w, a}, 16, 200, resp);
		chk(resp[15:8], exp);
	endtask
	// ********************
	// Watchdog
	// ********************
	initial begin
		repeat (40000) @(posedge clk);
		n_fail++;
		$display("watchdog expired");
		test_done();
	end
	// ********************
	// Tests
	// ********************
	initial begin
		resetn = 1'b0;
		{busAddr, busWdata, busWr, busRd} = 18'h0_0000;
		{wakeEvent, restartReq, failEvent} = 3'b000;
		supplyFlags = 8'h00;
		hsFault = 4'h0;
		wakePinLevel = 3'b101;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		// Reset state, mask and unmapped place
		rdchk(REG_MODE, 8'h00);
		chk({modeNow, hsEnable, canMode, failOut, irq}, 16'h0000);
		rdchk(MODE_CTRL, CTRL_RST);
		rdchk(8'h90, 8'h00);
		wr(REG_IRQ_MASK, 8'h0F);
		rdchk(REG_IRQ_MASK, 8'h0F);
		$display("reset test done");
		// Control access: write shows only in a later frame
		spi(BUS_CTRL_A, 1'b1, 8'h19, 8'h00);
		spi(BUS_CTRL_A, 1'b0, 8'hFF, 8'h19);
		spi(BUS_CTRL_A, 1'b0, 8'h00, 8'h19);
		chk({canMode, lin1Mode}, {CAN_WAKE, 2'b11});
		spi(CTRL_LAST, 1'b1, 8'hA5, 8'h00);
		rdchk(CTRL_LAST, 8'hA5);
		chk(irq, 1'b1);
		rdchk(REG_IRQ_STS, 8'h01);
		wr(REG_IRQ_STS, 8'h01);
		rdchk(REG_IRQ_STS, 8'h00);
		$display("control test done");
		// Status: plain read, write-clear, fixed and live registers
		ev(4'h0, 3'b001, 8'h04);
		chk(failOut, 1'b1);
		spi(STS_DEV, 1'b0, 8'h00, 8'h01);
		chk(resp[7:0], 8'h03);
		spi(STS_DEV, 1'b0, 8'h00, 8'h01);
		spi(STS_DEV, 1'b1, 8'h00, 8'h01);
		spi(STS_DEV, 1'b0, 8'h00, 8'h00);
		chk(resp[7:0], 8'h01);
		spi(STS_SUPPLY, 1'b1, 8'h00, 8'h04);
		spi(STS_WAKE_LVL, 1'b1, 8'h00, 8'h05);
		@(posedge clk);
		wakePinLevel <= 3'b010;
		spi(STS_WAKE_LVL, 1'b1, 8'h00, 8'h02);
		repeat (2) spi(STS_FAM_ID, 1'b1, 8'h00, 8'h5A);
		ev(4'h1, 3'b000, 8'h00);
		spi(HS_CTRL, 1'b1, 8'h0F, 8'h00);
		chk(hsEnable, 4'hF);
		spi(STS_HS_OVL, 1'b0, 8'h00, 8'h01);
		wr(REG_IRQ_STS, 8'h0F);
		$display("status test done");
		// Sleep, fault in sleep, wake into restart
		spi(BUS_CTRL_B, 1'b1, 8'h02, 8'h00);
		spi(BUS_CTRL_A, 1'b1, 8'h1A, 8'h19);
		spi(MODE_CTRL, 1'b1, 8'h68, 8'h00);
		chk({modeNow, thirdRegOn, secondRegOn}, {MD_SLEEP, 3'b101});
		chk({canMode, lin1Mode, lin2Mode}, {CAN_WAKE, LIN_WAKE, LIN_WAKE});
		spi(MODE_CTRL, 1'b0, 8'h00, 8'h68);
		spi(BUS_CTRL_A, 1'b0, 8'h00, 8'h09);
		spi(HS_CTRL, 1'b1, 8'h00, 8'h0F);
		chk(hsEnable, 4'hF);
		ev(4'h3, 3'b000, 8'h00);
		chk({modeNow, hsEnable, failOut}, {MD_SLEEP, 4'hC, 1'b1});
		ev(4'h0, 3'b100, 8'h00);
		chk({modeNow, hsEnable, secondRegOn, failOut}, {MD_RESTART, 4'h0, 2'b00, 1'b1});
		chk({canMode, lin1Mode, lin2Mode}, {CAN_WAKE, LIN_WAKE, LIN_WAKE});
		i_master.xfer(sbcra_frame_t'{8'h00, 1'b1, CTRL_LAST}, 16, 200, resp);
		chk(resp, 16'hFFFF);
		repeat (RST_CYC) @(posedge clk);
		#1;
		chk(modeNow, MD_NORMAL);
		rdchk(CTRL_LAST, 8'hA5);
		spi(MODE_CTRL, 1'b0, 8'h00, 8'h20);
		rdchk(REG_IRQ_STS, 8'h0D);
		$display("sleep test done");
		// Stop keeps transceivers; left by writing normal
		spi(BUS_CTRL_A, 1'b1, 8'h1A, 8'h09);
		spi(MODE_CTRL, 1'b1, 8'h80, 8'h20);
		chk({modeNow, canMode, lin1Mode}, {MD_STOP, 3'b010, 2'b11});
		spi(MODE_CTRL, 1'b1, 8'h00, 8'h80);
		chk(modeNow, MD_NORMAL);
		// Stop again, left by a wake; mode bits must follow
		spi(MODE_CTRL, 1'b1, 8'h80, 8'h00);
		ev(4'h0, 3'b100, 8'h00);
		chk(modeNow, MD_NORMAL);
		spi(MODE_CTRL, 1'b0, 8'h00, 8'h00);
		$display("stop test done");
		// Short frame refused; mask, read-only place, restart request
		wr(REG_IRQ_STS, 8'h0F);
		i_master.xfer(sbcra_frame_t'{8'h3C, 1'b1, CTRL_LAST}, 15, 200, resp);
		rdchk(CTRL_LAST, 8'hA5);
		rdchk(REG_IRQ_STS, 8'h02);
		chk(irq, 1'b1);
		wr(REG_IRQ_MASK, 8'h00);
		repeat (3) @(posedge clk);
		#1;
		chk(irq, 1'b0);
		wr(REG_IRQ_STS, 8'h02);
		rdchk(REG_IRQ_STS, 8'h00);
		wr(REG_MODE, 8'hFF);
		rdchk(REG_MODE, 8'h00);
		ev(4'h0, 3'b010, 8'h00);
		chk(modeNow, MD_RESTART);
		repeat (RST_CYC + 20) @(posedge clk);
		#1;
		chk(modeNow, MD_NORMAL);
		$display("refusal test done");
		test_done();
	end
endmodule // sbcra_reg_access_test
`default_nettype wire
